/* design/lbr_pkg.sv */
// constants, field layouts and carrier types of the led blink and ramp timer
// assumes a 100 MHz clock and registers written by the serial decoder
package lbr_pkg;
	// register indexes as decoded by the serial interface
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_PERIOD  = 4'h1;
	localparam logic [3:0] ADDR_ON_1    = 4'h2;
	localparam logic [3:0] ADDR_ON_2    = 4'h3;
	localparam logic [3:0] ADDR_MODE    = 4'h4;
	localparam logic [3:0] ADDR_RAMP    = 4'h5;

	// field positions
	localparam int SCALE_LSB   = 5;
	localparam int SHAPE_BIT   = 7;
	localparam int RISE_LSB    = 0;
	localparam int FALL_LSB    = 4;
	localparam int MODE_W      = 2;
	localparam int MODE_USED_W = 6;

	// reset values
	localparam logic [1:0] SCALE_RST = 2'h0;
	localparam logic [7:0] PERIOD_RST = 8'h00;
	localparam logic [7:0] ON_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] RAMP_RST = 8'h00;

	// timing: one blink slice is 1/256 of the 0.128 s period unit
	localparam int CLK_PERIOD_NS = 10;
	localparam int SLICE_NS = 500_000;
	localparam int SLICE_CYC = SLICE_NS / CLK_PERIOD_NS;
	// one ramp tick is 1/15 of the 1.5 ms minimum ramp: sixteen levels
	// give fifteen steps, so the last level lands on the full duration
	localparam int RAMP_TICK_NS = 100_000;
	localparam int RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;
	localparam int SLICES_PER_UNIT = 256;
	localparam logic [7:0] PERIOD_CODE1_UNITS = 8'h03;
	// ramp ticks per step for one duration code at each scaling
	localparam logic [11:0] TICKS_NORMAL = 12'h0040;
	localparam logic [11:0] TICKS_SLOW2 = 12'h0080;
	localparam logic [11:0] TICKS_SLOW4 = 12'h0100;
	localparam logic [11:0] TICKS_FAST8 = 12'h0008;
	localparam logic [11:0] TICKS_CODE0 = 12'h0001;
	localparam int RAMP_POS_W = 4;

	typedef enum logic [1:0] {
		LBR_MODE_OFF   = 2'h0,
		LBR_MODE_ON    = 2'h1,
		LBR_MODE_TMR_1 = 2'h2,
		LBR_MODE_TMR_2 = 2'h3
	} lbr_mode_t;

	// per-channel output toward the current sink
	typedef struct packed {
		logic       lit;
		logic [7:0] level;
	} lbr_chan_t;

	// register write request from the serial decoder
	typedef struct packed {
		logic       en;
		logic [3:0] addr;
		logic [7:0] data;
	} lbr_wr_t;
endpackage

/* design/lbr_top.sv */
// led blink timers and current ramps for three channels
// assumes register writes arrive already decoded, one per cycle
`timescale 1ns/1ps
module lbr_top #(
	parameter int SLICE_CYC     = lbr_pkg::SLICE_CYC,
	parameter int RAMP_TICK_CYC = lbr_pkg::RAMP_TICK_CYC,
	parameter int CHANNELS      = 3
) (
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire lbr_pkg::lbr_wr_t              wr,
	input  wire logic [3:0]                    rd_addr,
	output logic [7:0]                         rd_data,
	output lbr_pkg::lbr_chan_t [CHANNELS-1:0]  chan_out
);

	////////////////////////////////////////////////////////////////////
	// registers

	logic [1:0] scale, next_scale;
	logic [7:0] blink_period_and_ramp_shape, next_period;
	logic [7:0] blink_on_fraction_first, next_on_1;
	logic [7:0] blink_on_fraction_second, next_on_2;
	logic [7:0] channel_mode_select, next_mode;
	logic [7:0] ramp_rise_fall_durations, next_ramp;
	logic [7:0] next_rd_data;

	always_comb begin
		next_scale = scale;
		next_period = blink_period_and_ramp_shape;
		next_on_1 = blink_on_fraction_first;
		next_on_2 = blink_on_fraction_second;
		next_mode = channel_mode_select;
		next_ramp = ramp_rise_fall_durations;
		if (wr.en) begin
			unique case (wr.addr)
				lbr_pkg::ADDR_CONTROL: begin
					next_scale = wr.data[lbr_pkg::SCALE_LSB +: 2];
				end
				lbr_pkg::ADDR_PERIOD: next_period = wr.data;
				lbr_pkg::ADDR_ON_1: next_on_1 = wr.data;
				lbr_pkg::ADDR_ON_2: next_on_2 = wr.data;
				// unused top bits kept at zero
				lbr_pkg::ADDR_MODE: begin
					next_mode = {2'h0,
						wr.data[lbr_pkg::MODE_USED_W-1:0]};
				end
				lbr_pkg::ADDR_RAMP: next_ramp = wr.data;
				default: ;
			endcase
		end
		unique case (rd_addr)
			lbr_pkg::ADDR_CONTROL: next_rd_data = {1'b0, scale, 5'h00};
			lbr_pkg::ADDR_PERIOD: next_rd_data = blink_period_and_ramp_shape;
			lbr_pkg::ADDR_ON_1: next_rd_data = blink_on_fraction_first;
			lbr_pkg::ADDR_ON_2: next_rd_data = blink_on_fraction_second;
			lbr_pkg::ADDR_MODE: next_rd_data = channel_mode_select;
			lbr_pkg::ADDR_RAMP: next_rd_data = ramp_rise_fall_durations;
			default: next_rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scale <= lbr_pkg::SCALE_RST;
			blink_period_and_ramp_shape <= lbr_pkg::PERIOD_RST;
			blink_on_fraction_first <= lbr_pkg::ON_RST;
			blink_on_fraction_second <= lbr_pkg::ON_RST;
			channel_mode_select <= lbr_pkg::MODE_RST;
			ramp_rise_fall_durations <= lbr_pkg::RAMP_RST;
			rd_data <= 8'h00;
		end else begin
			scale <= next_scale;
			blink_period_and_ramp_shape <= next_period;
			blink_on_fraction_first <= next_on_1;
			blink_on_fraction_second <= next_on_2;
			channel_mode_select <= next_mode;
			ramp_rise_fall_durations <= next_ramp;
			rd_data <= next_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	// dividers: slice enable for blinking, tick enable for ramps

	logic [15:0] slice_div, next_slice_div;
	logic [15:0] tick_div, next_tick_div;
	logic        slice_en;
	logic        tick_en;

	assign slice_en = (slice_div == 16'(SLICE_CYC - 1));
	assign tick_en = (tick_div == 16'(RAMP_TICK_CYC - 1));

	always_comb begin
		next_slice_div = slice_en ? 16'h0000 : slice_div + 16'h0001;
		next_tick_div = tick_en ? 16'h0000 : tick_div + 16'h0001;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slice_div <= 16'h0000;
			tick_div <= 16'h0000;
		end else begin
			slice_div <= next_slice_div;
			tick_div <= next_tick_div;
		end
	end

	////////////////////////////////////////////////////////////////////
	// blink timers

	logic [7:0]  period_units;
	logic [15:0] period_slices;
	logic [15:0] on_slices_1;
	logic [15:0] on_slices_2;
	logic [15:0] slice_pos, next_slice_pos;
	logic        blink_timer_first;
	logic        blink_timer_second;

	always_comb begin
		// code 0 is one unit, code n is n+2 units
		if (blink_period_and_ramp_shape[6:0] == 7'h00) begin
			period_units = 8'h01;
		end else begin
			period_units = {1'b0, blink_period_and_ramp_shape[6:0]}
				+ lbr_pkg::PERIOD_CODE1_UNITS - 8'h01;
		end
		period_slices = 16'(period_units * lbr_pkg::SLICES_PER_UNIT);
		// lit interval: code/256 of the period, shared period
		on_slices_1 = 16'(blink_on_fraction_first) * 16'(period_units);
		on_slices_2 = 16'(blink_on_fraction_second) * 16'(period_units);
		next_slice_pos = slice_pos;
		if (slice_pos >= period_slices) begin
			// period shortened under a running count
			next_slice_pos = 16'h0000;
		end else if (slice_en) begin
			if (slice_pos + 16'h0001 >= period_slices) begin
				next_slice_pos = 16'h0000;
			end else begin
				next_slice_pos = slice_pos + 16'h0001;
			end
		end
		// the rise ramp starts at period start, inside the lit time
		blink_timer_first = (slice_pos < on_slices_1);
		blink_timer_second = (slice_pos < on_slices_2);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slice_pos <= 16'h0000;
		end else begin
			slice_pos <= next_slice_pos;
		end
	end

	////////////////////////////////////////////////////////////////////
	// ramps

	function automatic logic [11:0] ramp_ticks(
		input logic [3:0] code,
		input logic [1:0] sc
	);
		logic [11:0] per_code;
		per_code = lbr_pkg::TICKS_NORMAL;
		unique case (sc)
			2'h0: per_code = lbr_pkg::TICKS_NORMAL;
			2'h1: per_code = lbr_pkg::TICKS_SLOW2;
			2'h2: per_code = lbr_pkg::TICKS_SLOW4;
			2'h3: per_code = lbr_pkg::TICKS_FAST8;
		endcase
		// code zero ignores the scaling
		if (code == 4'h0) begin
			ramp_ticks = lbr_pkg::TICKS_CODE0;
		end else begin
			ramp_ticks = 12'(per_code * code);
		end
	endfunction

	function automatic logic [7:0] ramp_curve(
		input logic [3:0] pos,
		input logic       linear
	);
		logic [7:0] s_curve [16];
		s_curve = '{8'h00, 8'h02, 8'h08, 8'h12, 8'h20, 8'h31, 8'h46,
			8'h5f, 8'h80, 8'ha1, 8'hba, 8'hcf, 8'he0, 8'hee, 8'hf8,
			8'hff};
		if (linear) begin
			ramp_curve = 8'(pos * 8'h11);
		end else begin
			ramp_curve = s_curve[pos];
		end
	endfunction

	logic [11:0] rise_ticks;
	logic [11:0] fall_ticks;

	// one scaling for both directions
	assign rise_ticks = ramp_ticks(
		ramp_rise_fall_durations[lbr_pkg::RISE_LSB +: 4], scale);
	assign fall_ticks = ramp_ticks(
		ramp_rise_fall_durations[lbr_pkg::FALL_LSB +: 4], scale);

	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		logic [1:0]  mode;
		logic        target;
		logic [11:0] step_cnt, next_step_cnt;
		logic [3:0]  pos, next_pos;
		logic [11:0] limit;

		// first channel in the lowest bits
		assign mode = channel_mode_select[c*lbr_pkg::MODE_W +: 2];

		always_comb begin
			unique case (mode)
				lbr_pkg::LBR_MODE_OFF: target = 1'b0;
				lbr_pkg::LBR_MODE_ON: target = 1'b1;
				lbr_pkg::LBR_MODE_TMR_1: target = blink_timer_first;
				lbr_pkg::LBR_MODE_TMR_2: target = blink_timer_second;
			endcase
			// ramp between zero and nominal in either direction
			limit = target ? rise_ticks : fall_ticks;
			next_pos = pos;
			next_step_cnt = step_cnt;
			if ((target && pos == 4'hf) || (!target && pos == 4'h0)) begin
				next_step_cnt = 12'h000;
			end else if (tick_en) begin
				if (step_cnt + 12'h001 >= limit) begin
					next_step_cnt = 12'h000;
					next_pos = target ? pos + 4'h1 : pos - 4'h1;
				end else begin
					next_step_cnt = step_cnt + 12'h001;
				end
			end
		end

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				step_cnt <= 12'h000;
				pos <= 4'h0;
				chan_out[c] <= '0;
			end else begin
				step_cnt <= next_step_cnt;
				pos <= next_pos;
				chan_out[c].lit <= target;
				chan_out[c].level <= ramp_curve(next_pos,
					blink_period_and_ramp_shape[lbr_pkg::SHAPE_BIT]);
			end
		end
	end

endmodule

/* dv/lbr_assertions.sv */
// port checks for the led blink and ramp timer
// assumes it is bound to lbr_top
`timescale 1ns/1ps
module lbr_assertions #(
	parameter int SLICE_CYC     = 4,
	parameter int RAMP_TICK_CYC = 2,
	parameter int CHANNELS      = 3
) (
	input wire logic                              clk,
	input wire logic                              rst_b,
	input wire lbr_pkg::lbr_wr_t                  wr,
	input wire logic [3:0]                        rd_addr,
	input wire logic [7:0]                        rd_data,
	input wire lbr_pkg::lbr_chan_t [CHANNELS-1:0] chan_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_mode_wr(sel);
		wr.en && wr.addr == 4'h4 && sel ##1 !wr.en;
	endsequence
	chk_mode_on: assert property (
		s_mode_wr(wr.data[1:0] == 2'h1) |-> ##1 chan_out[0].lit)
		else $error("first channel not lit");
	chk_third_off: assert property (
		s_mode_wr(wr.data[5:4] == 2'h0) |-> ##1 !chan_out[2].lit)
		else $error("third channel still lit");
	chk_ctrl_bits: assert property (
		rd_addr == 4'h0 |=> rd_data[7] == 1'b0 && rd_data[4:0] == 5'h00)
		else $error("control unused bits set");
	chk_mode_top: assert property (
		rd_addr == 4'h4 |=> rd_data[7:6] == 2'h0)
		else $error("mode top bits set");
	// direction is judged one cycle after lit settles, reversal allowed
	chk_rise_up: assert property (
		chan_out[0].lit && $past(chan_out[0].lit)
		|-> chan_out[0].level >= $past(chan_out[0].level))
		else $error("level fell while lit");
	chk_fall_down: assert property (
		!chan_out[0].lit && !$past(chan_out[0].lit)
		|-> chan_out[0].level <= $past(chan_out[0].level))
		else $error("level rose while dark");
	chk_full_hold: assert property (
		chan_out[0].lit && chan_out[0].level == 8'hFF ##1 chan_out[0].lit
		|-> chan_out[0].level == 8'hFF)
		else $error("full level not held");
	chk_step_gap: assert property (
		$changed(chan_out[0].level) |=> $stable(chan_out[0].level))
		else $error("ramp stepped faster than tick");
endmodule

/* dv/lbr_sink_model.sv */
// current sink stand-in for the three ramp outputs
// assumes level 255 means nominal current
`timescale 1ns/1ps
module lbr_sink_model (
	input  wire lbr_pkg::lbr_chan_t [2:0] chan,
	output logic [2:0]                    full
);
	// a sink reports nominal only when the ramp sits at its top
	always_comb begin
		for (int i = 0; i < 3; i++) full[i] = chan[i].level === 8'hFF;
	end
endmodule

/* dv/led_blink_ramp_timing_tb.sv */
// self-checking bench for the led blink and ramp timer
// assumes lbr_top, the sink model and the checker are compiled first
`timescale 1ns/1ps
module led_blink_ramp_timing_tb;
	logic                     clk;
	logic                     rst_b;
	lbr_pkg::lbr_wr_t         wr;
	logic [3:0]               rd_addr;
	logic [7:0]               rd_data;
	lbr_pkg::lbr_chan_t [2:0] chan_out;
	logic [2:0]               full;
	int                       miscompares;
	int                       compares;
	int                       n;
	int                       hi;
	int                       lo;
	bit                       odd;
	int                       rise_us [4] = '{96_000, 192_000, 384_000,
	                                          12_000};
	localparam int            TB_TICK = 2;
	always #5 clk = ~clk;
	// short slices and ticks keep the longest ramp near 8000 cycles
	lbr_top #(.SLICE_CYC(4), .RAMP_TICK_CYC(TB_TICK)) u_dut (.clk(clk),
		.rst_b(rst_b), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
		.chan_out(chan_out));
	lbr_sink_model u_sink (.chan(chan_out), .full(full));
	////////////////////////////////////////
	task finish_test();
		$display("miscompares %0d compares %0d", miscompares, compares);
		if (miscompares == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input bit ok, input string m);
		compares++;
		if (!ok) begin
			miscompares++;
			$display("Error %0t %s", $time, m);
		end
	endtask
	// rule durations in microseconds, rescaled to the shortened tick
	function automatic int ramp_cyc(input int us);
		return us * 100 / lbr_pkg::RAMP_TICK_CYC * TB_TICK;
	endfunction
	// a ramp may end up to two cycles early, as the tick runs freely
	function automatic bit near(input int got, input int want);
		return got >= want - 2 && got <= want;
	endfunction
	task tmo();
		chk(1'b0, "wait limit");
		finish_test();
	endtask
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) wr <= {1'b1, a, d};
		@(posedge clk) wr <= '0;
	endtask
	task rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk) rd_addr <= a;
		@(posedge clk) #1;
		chk(rd_data === e, "read back");
	endtask
	task lvl(input int c, input logic [7:0] v, output int k, output bit o);
		k = 0;
		o = 0;
		while (chan_out[c].level !== v) begin
			@(posedge clk) #1;
			k++;
			if (chan_out[c].level % 17 != 0) o = 1;
			if (k > 9000) tmo();
		end
	endtask
	task run(input int c, input bit v, output int k);
		k = 0;
		while (chan_out[c].lit === v) begin
			@(posedge clk) #1;
			k++;
			if (k > 4000) tmo();
		end
	endtask
	task t_regs();
		for (int a = 0; a < 7; a++) rd_chk(a[3:0], 8'h00);
		wr_reg(4'h0, 8'hFF);
		rd_chk(4'h0, 8'h60);
		wr_reg(4'h4, 8'hFF);
		rd_chk(4'h4, 8'h3F);
		wr_reg(4'h6, 8'hFF);
		rd_chk(4'h6, 8'h00);
		wr_reg(4'h5, 8'hA5);
		rd_chk(4'h5, 8'hA5);
		wr_reg(4'h4, 8'h00);
		lvl(0, 8'h00, n, odd);
	endtask
	task t_ramps();
		for (int s = 0; s < 4; s++) begin
			wr_reg(4'h0, {1'b0, s[1:0], 5'h00});
			wr_reg(4'h5, 8'h01);
			wr_reg(4'h4, 8'h01);
			lvl(0, 8'hFF, n, odd);
			chk(near(n, ramp_cyc(rise_us[s])), "rise");
			chk(odd && full[0] === 1'b1, "s ramp");
			chk(chan_out[1].lit === 1'b0 && chan_out[2].lit === 1'b0, "on");
			wr_reg(4'h4, 8'h00);
			lvl(0, 8'h00, n, odd);
			chk(near(n, ramp_cyc(1_500)), "short fall");
		end
		wr_reg(4'h5, 8'h10);
		wr_reg(4'h4, 8'h01);
		lvl(0, 8'hFF, n, odd);
		chk(near(n, ramp_cyc(1_500)), "short rise");
		wr_reg(4'h4, 8'h00);
		lvl(0, 8'h00, n, odd);
		chk(near(n, ramp_cyc(rise_us[3])), "scaled fall");
		wr_reg(4'h0, 8'h00);
	endtask
	task t_shape();
		wr_reg(4'h1, 8'h80);
		wr_reg(4'h5, 8'h00);
		wr_reg(4'h4, 8'h01);
		lvl(0, 8'hFF, n, odd);
		chk(!odd, "linear rise");
		wr_reg(4'h4, 8'h00);
		lvl(0, 8'h00, n, odd);
		chk(!odd, "linear fall");
		wr_reg(4'h1, 8'h00);
	endtask
	task pulse(input int c);
		run(c, 1'b1, n);
		run(c, 1'b0, n);
		run(c, 1'b1, hi);
		run(c, 1'b0, lo);
	endtask
	task t_blink();
		wr_reg(4'h2, 8'h40);
		wr_reg(4'h3, 8'h80);
		wr_reg(4'h4, 8'h38);
		pulse(1);
		chk(hi > 254 && hi < 258 && lo > 766 && lo < 770, "t1");
		lvl(1, 8'hFF, n, odd);
		chk(n <= ramp_cyc(1_500) && chan_out[1].lit === 1, "rise");
		pulse(2);
		chk(hi > 510 && hi < 514 && lo > 510 && lo < 514, "t2");
		lvl(2, 8'hFF, n, odd);
		chk(n <= ramp_cyc(1_500) && chan_out[2].lit === 1, "rise");
		wr_reg(4'h1, 8'h01);
		pulse(1);
		chk(hi > 766 && hi < 770 && lo > 2302 && lo < 2306, "per");
	endtask
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		wr = '0;
		rd_addr = 4'h0;
		miscompares = 0;
		compares = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_ramps();
		t_shape();
		t_blink();
		finish_test();
	end
endmodule
bind lbr_top lbr_assertions #(.SLICE_CYC(SLICE_CYC),
	.RAMP_TICK_CYC(RAMP_TICK_CYC), .CHANNELS(CHANNELS)) u_chk (.clk(clk),
	.rst_b(rst_b), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
	.chan_out(chan_out));
